/* File: src/swbc_top.sv */
// sleep, wake, battery check and configuration registers of the transmitter controller
`default_nettype none
module swbc_top (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [5:0] cpu_addr_i,
  input  wire logic       cpu_wr_i,
  input  wire logic [7:0] cpu_wdata_i,
  output logic      [7:0] cpu_rdata_o,
  input  wire logic [7:0] ext_rdata_i,
  output logic            ext_wr_o,
  output logic      [5:0] ext_addr_o,
  output logic      [7:0] ext_wdata_o,
  input  wire logic       spi_mode_select_n_i,
  input  wire logic [5:0] pin_in_i,
  output logic      [5:0] pin_out_o,
  output logic      [5:0] pin_oe_n_o,
  input  wire logic [5:0] pin_output_enable_i,
  input  wire logic [5:0] pin_output_value_i,
  input  wire logic       tx_key_i,
  input  wire logic       lock_detect_i,
  input  wire logic       tx_enable_i,
  input  wire logic       batt_below_i,
  input  wire logic       batt_dead_i,
  output logic            batt_sample_o,
  output logic      [5:0] battery_level_code_o,
  output logic            cpu_clk_tick_o,
  output logic            cpu_reset_o,
  output logic            osc_run_o,
  output logic            wdt_run_o
);

  typedef struct packed {
    logic [8:0]          sync1;
    logic [8:0]          sync2;
    logic [8:0]          sync3;
    logic [8:0]          filt;
    swbc_pkg::swbc_state_e state;
    logic [6:0]          div_cnt;
    logic                cpu_tick;
    logic                spi_tick;
    logic [1:0]          cfg_div;
    logic                cfg_tm;
    logic                cfg_bd;
    logic                cfg_bbm;
    logic [5:0]          bdet;
    logic                bl;
    logic                battery_low_valid;
    logic [5:0]          blcode;
    logic                bat_busy;
    logic [11:0]         bat_cnt;
    logic [11:0]         vld_wait;
    logic [5:0]          wake_mask;
    logic                sck_prev;
    logic [4:0]          spi_cnt;
    logic [15:0]         spi_rx;
    logic [7:0]          spi_tx;
    logic [7:0]          rdata;
    logic                cpu_rst;
    logic                osc_run;
    logic                wdt_run;
    logic [5:0]          pin_out;
    logic [5:0]          pin_oe_n;
    logic                ext_wr;
    logic [5:0]          ext_addr;
    logic [7:0]          ext_wdata;
  } swbc_s;

  swbc_s       q;
  swbc_s       next_q;
  logic [1:0]  rst_q;
  logic        rst_n;
  logic        spi_mode;
  logic        spi_rise;
  logic        spi_fall;
  logic [15:0] rx_shift;
  logic        reg_wr;
  logic [5:0]  reg_wa;
  logic [7:0]  reg_wd;
  logic        bat_done;
  logic [5:0]  btn_cfg;
  logic [5:0]  pressed;
  logic [6:0]  div_mask;

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // register read mux; the processor never sees the dead flag

  function automatic logic [7:0] rd_mux(input swbc_s s, input logic [5:0] a,
                                        input logic via_spi, input logic [7:0] ext);
    logic [7:0] r;
    r = ext;
    if (a == swbc_pkg::ADDR_CFG) begin
      r = 8'h00;
      r[swbc_pkg::CFG_DIV_LSB +: 2] = s.cfg_div;
      r[swbc_pkg::CFG_TM_BIT]       = s.cfg_tm;
      r[swbc_pkg::CFG_BD_BIT]       = s.cfg_bd & via_spi;
      r[swbc_pkg::CFG_BLI_BIT]      = s.bl;
      r[swbc_pkg::CFG_BBM_BIT]      = s.cfg_bbm;
    end else if (a == swbc_pkg::ADDR_BDET) begin
      r = {2'h0, s.bdet};
    end else if (a == swbc_pkg::ADDR_BLC) begin
      r = {s.bl, s.battery_low_valid, s.blcode};
    end else if (!via_spi) begin
      r = 8'h00;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // shared decode: one write port fed by the processor or the SPI host

  always_comb begin
    spi_mode = ~q.filt[swbc_pkg::SY_MODE];
    spi_rise = q.spi_tick & spi_mode & q.filt[2] & ~q.sck_prev;
    spi_fall = q.spi_tick & spi_mode & ~q.filt[2] & q.sck_prev;
    rx_shift = {q.spi_rx[14:0], q.filt[0]};
    btn_cfg  = ~pin_output_enable_i & pin_output_value_i;
    pressed  = btn_cfg & ~q.filt[5:0];
    bat_done = q.bat_busy & (q.bat_cnt == swbc_pkg::BATT_LAST);
    if (spi_rise && q.spi_cnt == swbc_pkg::SPI_FRAME_LAST && rx_shift[15]) begin
      reg_wr = 1'b1;
      reg_wa = rx_shift[13:8];
      reg_wd = rx_shift[7:0];
    end else begin
      // processor writes only count while it runs and SPI mode is off
      reg_wr = cpu_wr_i & ~spi_mode & (q.state == swbc_pkg::SWBC_RUN);
      reg_wa = cpu_addr_i;
      reg_wd = cpu_wdata_i;
    end
    case (q.cfg_div)
      2'b00:   div_mask = swbc_pkg::DIV_MASK_128;
      2'b01:   div_mask = swbc_pkg::DIV_MASK_64;
      2'b10:   div_mask = swbc_pkg::DIV_MASK_32;
      default: div_mask = swbc_pkg::DIV_MASK_16;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_q = q;
    // three stages, a change counts once stages two and three agree
    next_q.sync1 = {batt_dead_i, batt_below_i, spi_mode_select_n_i, pin_in_i};
    next_q.sync2 = q.sync1;
    next_q.sync3 = q.sync2;
    for (int i = 0; i < 9; i++) begin
      if (q.sync2[i] == q.sync3[i]) begin
        next_q.filt[i] = q.sync3[i];
      end
    end

    // clock generation; the counter is held at zero while the oscillator is off
    next_q.div_cnt  = q.osc_run ? q.div_cnt + 7'h01 : 7'h00;
    next_q.cpu_tick = q.osc_run && (q.state == swbc_pkg::SWBC_RUN) && !spi_mode &&
                      ((q.div_cnt & div_mask) == div_mask);
    next_q.spi_tick = q.osc_run && spi_mode &&
                      (q.div_cnt[3:0] == swbc_pkg::SPI_DIV_MASK);

    // register writes
    next_q.ext_wr = 1'b0;
    if (reg_wr) begin
      if (reg_wa == swbc_pkg::ADDR_CFG) begin
        next_q.cfg_div = reg_wd[swbc_pkg::CFG_DIV_LSB +: 2];
        next_q.cfg_tm  = reg_wd[swbc_pkg::CFG_TM_BIT];
        next_q.cfg_bbm = reg_wd[swbc_pkg::CFG_BBM_BIT];
      end else if (reg_wa == swbc_pkg::ADDR_BDET) begin
        next_q.bdet = q.bdet & reg_wd[5:0];
      end else if (reg_wa == swbc_pkg::ADDR_BLC) begin
        next_q.blcode   = reg_wd[5:0];
        next_q.battery_low_valid      = 1'b0;
        next_q.bat_busy = 1'b1;
        next_q.bat_cnt  = 12'h000;
      end else begin
        next_q.ext_wr    = 1'b1;
        next_q.ext_addr  = reg_wa;
        next_q.ext_wdata = reg_wd;
      end
    end

    // battery comparison; a fresh write restarts the sample window
    if (q.bat_busy && !(reg_wr && reg_wa == swbc_pkg::ADDR_BLC)) begin
      next_q.bat_cnt = q.bat_cnt + 12'h001;
      if (bat_done) begin
        next_q.bat_busy = 1'b0;
        next_q.bl       = q.filt[swbc_pkg::SY_BELOW];
        next_q.battery_low_valid      = 1'b1;
        next_q.cfg_bd   = q.filt[swbc_pkg::SY_DEAD];
      end
    end

    // cycles since the last threshold write while valid is still low; feeds valid_time_a
    next_q.vld_wait = (reg_wr && reg_wa == swbc_pkg::ADDR_BLC) ? 12'h001 :
                      (q.vld_wait != 12'h000 && !q.battery_low_valid) ? q.vld_wait + 12'h001 : 12'h000;

    // button flags: hardware set beats a software clear in the same cycle
    if (q.state == swbc_pkg::SWBC_RUN && !q.cfg_bd) begin
      next_q.bdet = next_q.bdet | pressed;
    end

    next_q.cpu_rst = 1'b0;
    case (q.state)
      swbc_pkg::SWBC_RUN: begin
        if (reg_wr && reg_wa == swbc_pkg::ADDR_CFG && reg_wd[swbc_pkg::CFG_SLEEP_BIT]) begin
          next_q.state   = swbc_pkg::SWBC_SLEEP;
          next_q.osc_run = 1'b0;
          next_q.wdt_run = 1'b0;
        end
      end
      swbc_pkg::SWBC_SLEEP: begin
        if (|pressed) begin
          next_q.state     = swbc_pkg::SWBC_CHECK;
          next_q.osc_run   = 1'b1;
          next_q.wake_mask = pressed;
          next_q.bat_busy  = 1'b1;
          next_q.bat_cnt   = 12'h000;
        end
      end
      swbc_pkg::SWBC_CHECK: begin
        if (bat_done) begin
          if (q.filt[swbc_pkg::SY_DEAD]) begin
            next_q.state   = swbc_pkg::SWBC_SLEEP;
            next_q.osc_run = 1'b0;
          end else begin
            next_q.bdet = next_q.bdet | q.wake_mask;
            if (q.cfg_bbm) begin
              next_q.state   = swbc_pkg::SWBC_BTNRST;
              next_q.cpu_rst = 1'b1;
            end else begin
              next_q.state   = swbc_pkg::SWBC_RUN;
              next_q.wdt_run = 1'b1;
            end
          end
        end
      end
      swbc_pkg::SWBC_BTNRST: begin
        next_q.cfg_bbm = 1'b0;
        next_q.state   = swbc_pkg::SWBC_RUN;
        next_q.wdt_run = 1'b1;
      end
      default: begin
        next_q.state   = swbc_pkg::SWBC_RUN;
        next_q.osc_run = 1'b1;
      end
    endcase

    // SPI frame: bit 15 write, bits 13..8 address, bits 7..0 data, msb first
    if (!spi_mode) begin
      next_q.spi_cnt  = 5'h00;
      next_q.sck_prev = q.filt[2];
    end else if (q.spi_tick) begin
      next_q.sck_prev = q.filt[2];
      if (spi_rise) begin
        next_q.spi_rx  = rx_shift;
        next_q.spi_cnt = (q.spi_cnt == swbc_pkg::SPI_FRAME_LAST) ? 5'h00 : q.spi_cnt + 5'h01;
        if (q.spi_cnt == swbc_pkg::SPI_ADDR_BITS) begin
          next_q.ext_addr = rx_shift[5:0];
        end
      end else if (spi_fall) begin
        if (q.spi_cnt == swbc_pkg::SPI_DATA_START) begin
          next_q.spi_tx = rd_mux(q, q.spi_rx[5:0], 1'b1, ext_rdata_i);
        end else begin
          next_q.spi_tx = {q.spi_tx[6:0], 1'b0};
        end
      end
    end

    next_q.rdata = rd_mux(q, cpu_addr_i, 1'b0, ext_rdata_i);

    // pin routing
    next_q.pin_oe_n = ~pin_output_enable_i;
    next_q.pin_out  = pin_output_value_i;
    if (q.cfg_tm) begin
      next_q.pin_out[5:3] = {tx_key_i, lock_detect_i, tx_enable_i};
    end
    if (spi_mode) begin
      // clock and data in stay undriven; only the data out pin is driven
      next_q.pin_oe_n[2:0] = 3'b101;
      next_q.pin_out[2:0]  = {1'b0, q.spi_tx[7], 1'b0};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q          <= '0;
      q.sync1    <= swbc_pkg::SYNC_RESET;
      q.sync2    <= swbc_pkg::SYNC_RESET;
      q.sync3    <= swbc_pkg::SYNC_RESET;
      q.filt     <= swbc_pkg::SYNC_RESET;
      q.state    <= swbc_pkg::SWBC_RUN;
      q.osc_run  <= 1'b1;
      q.wdt_run  <= 1'b1;
      q.pin_oe_n <= 6'h3F;
    end else begin
      q <= next_q;
    end
  end

  assign cpu_rdata_o          = q.rdata;
  assign ext_wr_o             = q.ext_wr;
  assign ext_addr_o           = q.ext_addr;
  assign ext_wdata_o          = q.ext_wdata;
  assign pin_out_o            = q.pin_out;
  assign pin_oe_n_o           = q.pin_oe_n;
  assign batt_sample_o        = q.bat_busy;
  assign battery_level_code_o = q.blcode;
  assign cpu_clk_tick_o       = q.cpu_tick;
  assign cpu_reset_o          = q.cpu_rst;
  assign osc_run_o            = q.osc_run;
  assign wdt_run_o            = q.wdt_run;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  div_128_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (q.cpu_tick && $past(q.cfg_div) == 2'b00) |-> $past(q.div_cnt) == 7'h7F)
    else $error("divide by 128 tick out of place");
  spi_div_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    q.spi_tick |-> ($past(q.div_cnt[3:0]) == 4'hF && !q.cpu_tick))
    else $error("SPI tick not at crystal over 16");
  test_pin_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $past(q.cfg_tm) |-> pin_out_o[5] == $past(tx_key_i))
    else $error("test mode pin 5 not keyed signal");
  spi_pins_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $past(spi_mode) |-> pin_oe_n_o[2:0] == 3'b101)
    else $error("SPI pins follow output enables");
  bd_hidden_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $past(cpu_addr_i) == swbc_pkg::ADDR_CFG |-> !cpu_rdata_o[3])
    else $error("processor sees dead flag");
  mirror_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $past(cpu_addr_i) == swbc_pkg::ADDR_CFG |-> cpu_rdata_o[2] == $past(q.bl))
    else $error("battery low mirror differs");
  sleep_stop_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    q.state == swbc_pkg::SWBC_SLEEP |-> (!osc_run_o && !wdt_run_o) ##1 !cpu_clk_tick_o)
    else $error("clocks run in sleep");
  dead_back_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (q.state == swbc_pkg::SWBC_CHECK && bat_done && q.filt[swbc_pkg::SY_DEAD])
    |=> q.state == swbc_pkg::SWBC_SLEEP)
    else $error("dead battery did not return to sleep");
  bbm_exit_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    q.state == swbc_pkg::SWBC_BTNRST |-> cpu_reset_o ##1 (!q.cfg_bbm && !cpu_reset_o))
    else $error("button boot bit kept after reset state");
  upper_zero_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $past(cpu_addr_i) == swbc_pkg::ADDR_BDET |-> cpu_rdata_o[7:6] == 2'b00)
    else $error("flag register top bits set");
  valid_clr_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (reg_wr && reg_wa == swbc_pkg::ADDR_BLC) |=> !q.battery_low_valid)
    else $error("valid bit survived write");
  valid_time_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    q.vld_wait <= swbc_pkg::BATT_LAST + 12'h002)
    else $error("valid bit late");

endmodule // swbc_top
`default_nettype wire

/* File: src/swbc_pkg.sv */
// constants, register map and state encoding of the sleep, wake and battery control block
//
// Operation
// - divider code 00 gives crystal over 128
// - SPI mode logic runs at crystal over 16
// - test mode routes radio signals to pins
// - SPI mode pins 2..0 ignore output enables
// - SPI host reaches all I/O registers directly
// - battery dead flag readable over SPI only
// - configuration bit 2 mirrors battery low flag
// - sleep stops oscillator, processor and watchdog
// - button press wakes, dead battery sleeps again
// - button boot wake restarts at reset vector
// - button boot bit cleared at reset, exit
// - pressed button with good battery sets flag
// - writing zero clears flag, top bits zero
// - threshold register write clears valid bit
// - valid bit set within 3100 crystal cycles
// - battery low flag compares against threshold field
// - threshold field drives battery monitor code
// - enable 0 and value 1 means button
// - codes 11, 10, 01 divide 16, 32, 64
`default_nettype none
package swbc_pkg;
  localparam int          ADDR_W          = 6;
  localparam logic [5:0]  ADDR_CFG        = 6'h33;
  localparam logic [5:0]  ADDR_BDET       = 6'h34;
  localparam logic [5:0]  ADDR_BLC        = 6'h35;
  localparam logic [7:0]  CFG_RESET       = 8'h00;
  localparam logic [7:0]  BDET_RESET      = 8'h00;
  localparam logic [7:0]  BLC_RESET       = 8'h00;
  localparam int          CFG_DIV_LSB     = 5;
  localparam int          CFG_TM_BIT      = 4;
  localparam int          CFG_BD_BIT      = 3;
  localparam int          CFG_BLI_BIT     = 2;
  localparam int          CFG_SLEEP_BIT   = 1;
  localparam int          CFG_BBM_BIT     = 0;
  localparam int          BLC_BL_BIT      = 7;
  localparam int          BLC_BLV_BIT     = 6;
  localparam logic [6:0]  DIV_MASK_128    = 7'h7F;
  localparam logic [6:0]  DIV_MASK_64     = 7'h3F;
  localparam logic [6:0]  DIV_MASK_32     = 7'h1F;
  localparam logic [6:0]  DIV_MASK_16     = 7'h0F;
  localparam logic [3:0]  SPI_DIV_MASK    = 4'hF;
  localparam logic [4:0]  SPI_ADDR_BITS   = 5'h07;
  localparam logic [4:0]  SPI_DATA_START  = 5'h08;
  localparam logic [4:0]  SPI_FRAME_LAST  = 5'h0F;
  localparam int          BATT_SAMPLE_CYC = 3100;
  localparam logic [11:0] BATT_LAST       = 12'(BATT_SAMPLE_CYC - 1);
  // sync vector layout: pins 5..0, mode select, battery below, battery dead
  localparam int          SY_MODE         = 6;
  localparam int          SY_BELOW        = 7;
  localparam int          SY_DEAD         = 8;
  localparam logic [8:0]  SYNC_RESET      = 9'h07F;

  typedef enum logic [3:0] {
    SWBC_RUN    = 4'b0001,
    SWBC_SLEEP  = 4'b0010,
    SWBC_CHECK  = 4'b0100,
    SWBC_BTNRST = 4'b1000
  } swbc_state_e;
endpackage : swbc_pkg
`default_nettype wire

/* File: dv/swbc_io_model.sv */
// behavioural model of the I/O enable and data-out registers beside the block
`default_nettype none
module swbc_io_model #(
  parameter logic [7:0] ENAB_INIT = 8'h38,
  parameter logic [7:0] DOUT_INIT = 8'h01
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ext_wr_i,
  input  wire logic [5:0] ext_addr_i,
  input  wire logic [7:0] ext_wdata_i,
  output logic      [7:0] ext_rdata_o,
  output logic      [5:0] enab_o,
  output logic      [5:0] dout_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] enab;
  logic [7:0] dout;
  // pin 0 comes up as a button, pins 5..3 as outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enab <= ENAB_INIT;
      dout <= DOUT_INIT;
    end else if (ext_wr_i && ext_addr_i == 6'h30) begin
      enab <= ext_wdata_i;
    end else if (ext_wr_i && ext_addr_i == 6'h31) begin
      dout <= ext_wdata_i;
    end
  end
  // other addresses read a changing pattern rather than a stale value
  assign ext_rdata_o = (ext_addr_i == 6'h30) ? enab :
                       (ext_addr_i == 6'h31) ? dout : {2'h0, ext_addr_i} ^ 8'hA5;
  assign enab_o = enab[5:0];
  assign dout_o = dout[5:0];
endmodule // swbc_io_model
`default_nettype wire

/* File: dv/test_swbc_top.sv */
// self-checking bench of the sleep, wake and battery control block
`default_nettype none
module test_swbc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, mode_n = 1'b1, below = 1'b0, dead = 1'b0;
  logic key = 1'b0, lock = 1'b0, txen = 1'b0;
  logic [5:0] addr = 6'h00, drv = 6'h3F, pin_in, pin_out, oe_n, enab, dout, ext_addr, lvl;
  logic [7:0] wdata = 8'h00, rdata, ext_rd, ext_wd, d;
  logic ext_wr, smp, tick, crst, osc, wdt;
  int n_errors = 0, total_checks = 0, n, k;
  typedef struct { logic [7:0] cfg; logic [7:0] gap; } row_s;
  row_s rows [4] = '{'{8'h00, 8'h80}, '{8'h20, 8'h40}, '{8'h40, 8'h20}, '{8'h60, 8'h10}};
  always #12.5 clk = ~clk;
  // the pad level is whoever drives it: the block where enabled, the bench otherwise
  assign pin_in = (~oe_n & pin_out) | (oe_n & drv);
  swbc_top u_swbc_top (.ref_clk_i(clk), .rst_n_i(rst_n), .cpu_addr_i(addr), .cpu_wr_i(wr),
    .cpu_wdata_i(wdata), .cpu_rdata_o(rdata), .ext_rdata_i(ext_rd), .ext_wr_o(ext_wr),
    .ext_addr_o(ext_addr), .ext_wdata_o(ext_wd), .spi_mode_select_n_i(mode_n),
    .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_n_o(oe_n), .pin_output_enable_i(enab),
    .pin_output_value_i(dout), .tx_key_i(key), .lock_detect_i(lock), .tx_enable_i(txen),
    .batt_below_i(below), .batt_dead_i(dead), .batt_sample_o(smp),
    .battery_level_code_o(lvl), .cpu_clk_tick_o(tick), .cpu_reset_o(crst),
    .osc_run_o(osc), .wdt_run_o(wdt));
  swbc_io_model u_swbc_io_model (.clk_i(clk), .rst_n_i(rst_n), .ext_wr_i(ext_wr),
    .ext_addr_i(ext_addr), .ext_wdata_i(ext_wd), .ext_rdata_o(ext_rd), .enab_o(enab),
    .dout_o(dout));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic cpu_wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data is registered from the address of the previous edge
  task automatic cpu_rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    cyc(2);
    v = rdata;
  endtask
  task automatic tick_gap(output int g);
    k = 0;
    while (tick !== 1'b1 && k < 400) begin cyc(1); k++; end
    g = 0;
    do begin cyc(1); g++; end while (tick !== 1'b1 && g < 400);
  endtask
  // sck halves of 65 cycles stay well above the filter and tick sampling
  task automatic spi(input logic [15:0] f, output logic [7:0] v);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk);
      drv[0] <= f[i];
      drv[2] <= 1'b0;
      cyc(64);
      if (i < 8) v[i] = pin_in[1];
      @(posedge clk);
      drv[2] <= 1'b1;
      cyc(64);
    end
    @(posedge clk);
    drv[2] <= 1'b0;
    cyc(64);
  endtask
  // wait until the oscillator output reaches a level, bounded by a wake window
  task automatic wait_osc(input logic lv);
    k = 0;
    while (osc !== lv && k < 3300) begin cyc(1); k++; end
    check({7'h0, osc}, {7'h0, lv});
  endtask
  initial begin
    #1ms;
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    cyc(8);
    cpu_rd(6'h33, d); check(d, 8'h00);
    cpu_rd(6'h34, d); check(d, 8'h00);
    cpu_rd(6'h35, d); check(d, 8'h00);
    cpu_rd(6'h20, d); check(d, 8'h00);
    foreach (rows[r]) begin
      cpu_wr(6'h33, rows[r].cfg);
      tick_gap(n);
      tick_gap(n);
      check(8'(n), rows[r].gap);
    end
    // pin 0 is a button, pin 1 a plain input: only pin 0 may flag
    @(posedge clk); drv[1:0] <= 2'b00;
    cyc(12);
    @(posedge clk); drv[1:0] <= 2'b11;
    cpu_rd(6'h34, d); check(d, 8'h01);
    cpu_wr(6'h34, 8'hFF);
    cpu_rd(6'h34, d); check(d, 8'h01);
    cpu_wr(6'h34, 8'h00);
    cpu_rd(6'h34, d); check(d, 8'h00);
    // a button is configured before sleeping, as software must
    cpu_wr(6'h33, 8'h03);
    cyc(3);
    check({6'h0, osc, wdt}, 8'h00);
    n = 0;
    repeat (300) begin cyc(1); if (tick === 1'b1) n++; end
    check(8'(n), 8'h00);
    @(posedge clk); dead <= 1'b1; drv[0] <= 1'b0;
    wait_osc(1'b1);
    cyc(10);
    @(posedge clk); drv[0] <= 1'b1;
    wait_osc(1'b0);
    check({7'h0, wdt}, 8'h00);
    @(posedge clk); dead <= 1'b0; drv[0] <= 1'b0;
    k = 0;
    while (crst !== 1'b1 && k < 3400) begin cyc(1); k++; end
    check({7'h0, crst}, 8'h01);
    cyc(1);
    check({7'h0, crst}, 8'h00);
    @(posedge clk); drv[0] <= 1'b1;
    cyc(4);
    check({6'h0, osc, wdt}, 8'h03);
    cpu_rd(6'h33, d); check(d, 8'h00);
    cpu_rd(6'h34, d); check(d, 8'h01);
    @(posedge clk); below <= 1'b1; dead <= 1'b1;
    cpu_wr(6'h35, 8'h2A);
    cpu_rd(6'h35, d); check(d, 8'h2A);
    check({2'h0, lvl}, 8'h2A);
    check({7'h0, smp}, 8'h01);
    // valid lands 3100 edges after the write edge; the read below looks just after that
    repeat (3097) @(posedge clk);
    cpu_rd(6'h35, d); check(d, 8'hEA);
    check({7'h0, smp}, 8'h00);
    cpu_rd(6'h33, d); check(d, 8'h04);
    @(posedge clk); mode_n <= 1'b0; drv[2] <= 1'b0;
    cyc(200);
    check({5'h0, oe_n[2:0]}, 8'h05);
    spi(16'h3300, d); check(d, 8'h0C);
    spi(16'hB039, d);
    spi(16'h3000, d); check(d, 8'h39);
    spi(16'hB310, d);
    @(posedge clk); mode_n <= 1'b1; drv[2] <= 1'b1; key <= 1'b1; txen <= 1'b1;
    cyc(20);
    check({2'h0, oe_n[5:3], pin_out[5:3]}, 8'h05);
    @(posedge clk); key <= 1'b0; lock <= 1'b1;
    cyc(4);
    check({5'h0, pin_out[5:3]}, 8'h03);
    end_sim();
  end
endmodule // test_swbc_top
`default_nettype wire
